// ==== rtl/irq_option_and_pin_reset_control.sv ====
/*
 * Build-option, external request, reset pin and port reset control of a
 * small microcontroller, with an APB slave for port and status registers.
 * Assumes the core pulses instrBoundary at each instruction end, reports its
 * interrupt mask flag, and that all pins are synchronous to clk.
 */
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module irq_option_and_pin_reset_control
	import irq_opt_pkg::*;
#(
	parameter bit WATCHDOG_OPTION_ENABLE = 1'b1,
	parameter bit STOP_INSTRUCTION_OPTION_ENABLE = 1'b1,
	parameter bit IRQ_LEVEL_OPTION = 1'b0,
	parameter logic [7:0] PORT_B_PULLUP_OPTION = 8'hff
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic resetPinN,
	input wire logic lowPowerResetInN,
	input wire logic irqPinN,
	input wire logic instrBoundary,
	input wire logic iMaskFlag,
	input wire logic stopExec,
	input wire logic waitExec,
	output logic intStart,
	output logic coreReset,
	output logic busClkEn,
	output logic cpuClkEn,
	output logic watchdogRun,
	output logic oscillatorOutputEn,
	input wire logic [7:0] portAIn,
	output logic [7:0] portAOut,
	output logic [7:0] portAOe,
	input wire logic [7:0] portBIn,
	output logic [7:0] portBOut,
	output logic [7:0] portBOe,
	output logic [7:0] portBPullupEn,
	input wire logic [7:0] portCIn,
	output logic [7:0] portCOut,
	output logic [7:0] portCOe,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************
	// Reset and clock control
	// ****************************************
	logic sysRst;
	logic coreReset_ff;
	logic clocksRun;
	pwr_mode_t pwrMode_ff;
	pwr_mode_t nxt_pwrMode;

	// Either pin forces the startup state except prdata (reset pin: bus clock divider too); low-power reset also stops clocks
	assign sysRst = !resetPinN || !lowPowerResetInN;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			coreReset_ff <= 1'b1;
		end else begin
			coreReset_ff <= sysRst;
		end
	end

	assign coreReset = coreReset_ff;
	// Oscillator stays off while held in low-power reset or true stop
	assign clocksRun = lowPowerResetInN && pwrMode_ff != PM_STOP;
	assign oscillatorOutputEn = clocksRun;

	bus_clk_divider #(
		.DIV(BUS_CLK_DIV)
	) bus_clk_divider_i (
		.clk(clk),
		.nrst(nrst),
		.run(clocksRun),
		.busClkEn(busClkEn)
	);

	// Core halts in wait; peripherals keep the bus clock
	assign cpuClkEn = busClkEn && pwrMode_ff == PM_RUN && !coreReset_ff;

	// Watchdog frozen in true stop and during reset
	assign watchdogRun = WATCHDOG_OPTION_ENABLE && pwrMode_ff != PM_STOP && !coreReset_ff;

	// ****************************************
	// Interrupt request sensing
	// ****************************************
	logic [7:0] keyscanEnabled;
	logic keyscanAny;
	logic combinedReqN;
	logic reqQualified;
	logic setEvent;
	logic irqLatch;
	logic takeInt;
	logic intStart_ff;

	assign keyscanEnabled = PORT_B_PULLUP_OPTION;
	// Keyscan line low only counts where it is an input with its option set
	assign keyscanAny = |(~portBIn & keyscanEnabled & ~portBOe);
	// One detector for both sources, so keyscan shares the pin sensitivity
	assign combinedReqN = irqPinN && !keyscanAny;

	irq_sense_latch #(
		.MIN_CYC(MIN_IRQ_PULSE_CYC)
	) irq_sense_latch_i (
		.clk(clk),
		.nrst(nrst),
		.syncRst(sysRst),
		.reqN(combinedReqN),
		.levelMode(IRQ_LEVEL_OPTION),
		.clearReq(takeInt),
		.reqQualified(reqQualified),
		.setEvent(setEvent),
		.irqLatch(irqLatch)
	);

	// Latch is only looked at when the current instruction has ended
	assign takeInt = instrBoundary && irqLatch && !iMaskFlag && !coreReset_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intStart_ff <= 1'b0;
		end else begin
			intStart_ff <= takeInt && !sysRst;
		end
	end

	assign intStart = intStart_ff;

	// ****************************************
	// Power modes
	// ****************************************
	always_comb begin
		nxt_pwrMode = pwrMode_ff;
		unique case (pwrMode_ff)
			PM_RUN: begin
				if (stopExec) begin
					nxt_pwrMode = STOP_INSTRUCTION_OPTION_ENABLE ? PM_STOP : PM_WAIT;
				end else if (waitExec) begin
					nxt_pwrMode = PM_WAIT;
				end
			end
			PM_WAIT, PM_STOP: begin
				if (irqLatch) begin
					nxt_pwrMode = PM_RUN;
				end
			end
			default: begin
				nxt_pwrMode = PM_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwrMode_ff <= PM_RUN;
		end else if (sysRst) begin
			pwrMode_ff <= PM_RUN;
		end else begin
			pwrMode_ff <= nxt_pwrMode;
		end
	end

	// ****************************************
	// Port registers
	// ****************************************
	logic [7:0] portAData_ff;
	logic [7:0] portBData_ff;
	logic [7:0] portCData_ff;
	logic [7:0] portADir_ff;
	logic [7:0] portBDir_ff;
	logic [7:0] portCDir_ff;
	logic wrEn;
	logic rdSetup;

	assign wrEn = psel && penable && pwrite;
	assign rdSetup = psel && !penable && !pwrite;

	function automatic logic isWritable(input logic [ADDR_W-1:0] addr);
		isWritable = addr == PORTA_DATA_OFS || addr == PORTB_DATA_OFS ||
			addr == PORTC_DATA_OFS || addr == PORTA_DIR_OFS ||
			addr == PORTB_DIR_OFS || addr == PORTC_DIR_OFS;
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
		isMapped = isWritable(addr) || addr == STATUS_OFS || addr == OPTION_OFS;
	endfunction

	// Pin value for inputs, latch for outputs
	function automatic logic [7:0] portView(input logic [7:0] dir, input logic [7:0] data,
		input logic [7:0] pins);
		portView = (dir & data) | (~dir & pins);
	endfunction

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			portAData_ff <= PORT_DATA_RST;
			portBData_ff <= PORT_DATA_RST;
			portCData_ff <= PORT_DATA_RST;
		end else if (sysRst) begin
			portAData_ff <= PORT_DATA_RST;
			portBData_ff <= PORT_DATA_RST;
			portCData_ff <= PORT_DATA_RST;
		end else if (wrEn) begin
			if (paddr == PORTA_DATA_OFS) begin
				portAData_ff <= pwdata[7:0];
			end
			if (paddr == PORTB_DATA_OFS) begin
				portBData_ff <= pwdata[7:0];
			end
			if (paddr == PORTC_DATA_OFS) begin
				portCData_ff <= pwdata[7:0];
			end
		end
	end

	// All lines fall back to inputs on any reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			portADir_ff <= PORT_DIR_RST;
			portBDir_ff <= PORT_DIR_RST;
			portCDir_ff <= PORT_DIR_RST;
		end else if (sysRst) begin
			portADir_ff <= PORT_DIR_RST;
			portBDir_ff <= PORT_DIR_RST;
			portCDir_ff <= PORT_DIR_RST;
		end else if (wrEn) begin
			if (paddr == PORTA_DIR_OFS) begin
				portADir_ff <= pwdata[7:0];
			end
			if (paddr == PORTB_DIR_OFS) begin
				portBDir_ff <= pwdata[7:0];
			end
			// Upper bits kept so software can park unbonded lines as outputs
			if (paddr == PORTC_DIR_OFS) begin
				portCDir_ff <= pwdata[7:0];
			end
		end
	end

	assign portAOut = portAData_ff;
	assign portAOe = portADir_ff;
	assign portBOut = portBData_ff;
	assign portBOe = portBDir_ff;
	assign portCOut = portCData_ff;
	assign portCOe = portCDir_ff;
	assign portBPullupEn = keyscanEnabled;

	// ****************************************
	// APB read path
	// ****************************************
	logic [31:0] statusWord;
	logic [31:0] optionWord;

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_IRQ_LATCH] = irqLatch;
		statusWord[ST_WDOG_RUN] = watchdogRun;
		statusWord[ST_WAIT] = pwrMode_ff == PM_WAIT;
		statusWord[ST_STOP] = pwrMode_ff == PM_STOP;
		statusWord[ST_REQ_LOW] = reqQualified;
		statusWord[ST_KEYSCAN] = keyscanAny;
	end

	always_comb begin
		optionWord = 32'h0000_0000;
		optionWord[OPT_WDOG] = WATCHDOG_OPTION_ENABLE;
		optionWord[OPT_STOP] = STOP_INSTRUCTION_OPTION_ENABLE;
		optionWord[OPT_SENSE] = IRQ_LEVEL_OPTION;
		optionWord[OPT_PULLUP_LSB +: 8] = PORT_B_PULLUP_OPTION;
	end

	// Read data captured in the setup cycle, valid throughout the access phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (rdSetup) begin
			unique case (paddr)
				PORTA_DATA_OFS: prdata <= {24'h00_0000, portView(portADir_ff, portAData_ff, portAIn)};
				PORTB_DATA_OFS: prdata <= {24'h00_0000, portView(portBDir_ff, portBData_ff, portBIn)};
				PORTC_DATA_OFS: prdata <= {24'h00_0000, portView(portCDir_ff, portCData_ff, portCIn)};
				PORTA_DIR_OFS: prdata <= {24'h00_0000, portADir_ff};
				PORTB_DIR_OFS: prdata <= {24'h00_0000, portBDir_ff};
				PORTC_DIR_OFS: prdata <= {24'h00_0000, portCDir_ff};
				STATUS_OFS: prdata <= statusWord;
				OPTION_OFS: prdata <= optionWord;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Zero wait states; any unmapped access, or a write to a read-only register, flags an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && (!isMapped(paddr) || (pwrite && !isWritable(paddr)));

	// ****************************************
	// Assertions
	// ****************************************
	AST_WDOG_OPTION: assert property (@(posedge clk) disable iff (!nrst)
		(pwrMode_ff == PM_RUN && !coreReset_ff) |-> watchdogRun == WATCHDOG_OPTION_ENABLE)
		else $error("watchdog run does not follow its option");

	AST_STOP_AS_WAIT: assert property (@(posedge clk) disable iff (!nrst)
		(pwrMode_ff == PM_RUN && stopExec && !sysRst) |=>
		pwrMode_ff == (STOP_INSTRUCTION_OPTION_ENABLE ? PM_STOP : PM_WAIT))
		else $error("stop instruction entered the wrong mode");

	AST_LEVEL_REFIRE: assert property (@(posedge clk) disable iff (!nrst)
		(reqQualified && !sysRst && IRQ_LEVEL_OPTION) |=> irqLatch)
		else $error("held low request not relatched in level mode");

	AST_EDGE_ONCE: assert property (@(posedge clk) disable iff (!nrst)
		(setEvent && !IRQ_LEVEL_OPTION) |=> !setEvent)
		else $error("edge mode fired twice in one low period");

	AST_KEYSCAN_REQ: assert property (@(posedge clk) disable iff (!nrst)
		(keyscanAny && !sysRst)[*8] |-> reqQualified)
		else $error("keyscan low did not qualify a request");

	AST_LATCH_SET: assert property (@(posedge clk) disable iff (!nrst)
		(setEvent && !sysRst) |=> irqLatch)
		else $error("qualified request did not set the latch");

	AST_TAKE_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
		intStart |-> $past(instrBoundary) && !$past(iMaskFlag) && $past(irqLatch))
		else $error("interrupt started without boundary, latch and clear mask");

	AST_LATCH_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
		intStart |-> !irqLatch || $past(setEvent))
		else $error("latch not cleared when interrupt started");

	AST_HALF_RATE: assert property (@(posedge clk) disable iff (!nrst)
		busClkEn |=> !busClkEn ##1
		(busClkEn || !$past(clocksRun) || !$past(clocksRun, 2)))
		else $error("bus clock enable not at half rate");

	AST_LOWPWR_HALT: assert property (@(posedge clk) disable iff (!nrst)
		!lowPowerResetInN |=> !busClkEn && coreReset && !cpuClkEn)
		else $error("clocks running during low power reset");

	AST_PORTS_INPUT: assert property (@(posedge clk) disable iff (!nrst)
		sysRst |=> portAOe == 8'h00 && portBOe == 8'h00 && portCOe == 8'h00)
		else $error("port lines not inputs after reset");

	COV_INT_TAKEN: cover property (@(posedge clk) disable iff (!nrst) intStart);
	COV_STOP_WAKE: cover property (@(posedge clk) disable iff (!nrst)
		pwrMode_ff == PM_STOP ##[1:50] pwrMode_ff == PM_RUN);
	COV_KEYSCAN: cover property (@(posedge clk) disable iff (!nrst) keyscanAny && setEvent);
	COV_LOWPWR: cover property (@(posedge clk) disable iff (!nrst) $fell(lowPowerResetInN));

endmodule

// ==== rtl/irq_opt_pkg.sv ====
/*
 * Shared constants for the option, interrupt-request and reset control block:
 * register offsets, field positions, reset values, timing counts, power modes.
 * Assumes a single 20 MHz clock and an APB register bus with 32-bit data.
 */
// Function
// - Watchdog option 1 runs the watchdog, 0 disables it.
// - Stop option 0 makes STOP behave exactly like WAIT; 1 gives true stop.
// - Sensitivity option 1 is falling edge plus low level; 0 is edge only.
// - Port B keyscan requests use the same sensitivity as the request pin.
// - Core finishes its current instruction before answering a pending request.
// - Request held low for the minimum pulse width sets the request latch.
// - At instruction boundary, latch set and mask clear start interrupt sequence.
// - Bus clock runs at half the oscillator input rate.
// - Reset pin low returns all logic to its startup state; the code does not reset the bus clock divider or prdata on it.
// - Low-power reset pin low holds reset with every processor clock stopped.
// - Any reset makes all eight port A lines inputs.
// - Any reset makes all port B lines inputs.
// - Each port B line has its own pull-up and keyscan build option.
// - Port C is a full 8-bit port, all inputs after any reset.
// - Port B option 1 enables pull-up and keyscan, 0 disables both.
package irq_opt_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_FREQ_HZ = 20000000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
	localparam int MIN_IRQ_PULSE_NS = 250;
	localparam int MIN_IRQ_PULSE_RAW = (MIN_IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_IRQ_PULSE_CYC = (MIN_IRQ_PULSE_RAW < 1) ? 1 : MIN_IRQ_PULSE_RAW;
	localparam int BUS_CLK_DIV = 2;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] PORTA_DATA_OFS = 8'h00;
	localparam logic [7:0] PORTB_DATA_OFS = 8'h04;
	localparam logic [7:0] PORTC_DATA_OFS = 8'h08;
	localparam logic [7:0] PORTA_DIR_OFS = 8'h0c;
	localparam logic [7:0] PORTB_DIR_OFS = 8'h10;
	localparam logic [7:0] PORTC_DIR_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [7:0] OPTION_OFS = 8'h1c;

	localparam logic [7:0] PORT_DATA_RST = 8'h00;
	localparam logic [7:0] PORT_DIR_RST = 8'h00;

	// Status fields
	localparam int ST_IRQ_LATCH = 0;
	localparam int ST_WDOG_RUN = 1;
	localparam int ST_WAIT = 2;
	localparam int ST_STOP = 3;
	localparam int ST_REQ_LOW = 4;
	localparam int ST_KEYSCAN = 5;

	// Option fields
	localparam int OPT_WDOG = 0;
	localparam int OPT_STOP = 1;
	localparam int OPT_SENSE = 2;
	localparam int OPT_PULLUP_LSB = 8;

	typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_STOP} pwr_mode_t;

endpackage

// ==== rtl/bus_clk_divider.sv ====
/*
 * Divides the oscillator clock into a one-cycle bus clock enable.
 * Assumes clk is the oscillator input and run drops whenever clocks must halt.
 */
`timescale 1ns/1ps
module bus_clk_divider
	import irq_opt_pkg::*;
#(
	parameter int DIV = BUS_CLK_DIV
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	output logic busClkEn
);

	logic [$clog2(DIV)-1:0] cnt_ff;
	logic busClkEn_ff;

	// Counter restarts on halt so the first enable after release is a full period late
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else if (!run || cnt_ff == $clog2(DIV)'(DIV - 1)) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busClkEn_ff <= 1'b0;
		end else begin
			busClkEn_ff <= run && cnt_ff == $clog2(DIV)'(DIV - 1);
		end
	end

	assign busClkEn = busClkEn_ff;

endmodule

// ==== rtl/irq_sense_latch.sv ====
/*
 * Pulse-width qualifier, edge or edge-and-level sensing and request latch.
 * Assumes reqN is synchronous to clk and already combines every request source.
 */
`timescale 1ns/1ps
module irq_sense_latch
	import irq_opt_pkg::*;
#(
	parameter int MIN_CYC = MIN_IRQ_PULSE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic syncRst,
	input wire logic reqN,
	input wire logic levelMode,
	input wire logic clearReq,
	output logic reqQualified,
	output logic setEvent,
	output logic irqLatch
);

	localparam int CNT_W = $clog2(MIN_CYC + 1);

	logic [CNT_W-1:0] lowCnt_ff;
	logic armed_ff;
	logic irqLatch_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lowCnt_ff <= '0;
		end else if (syncRst || reqN) begin
			lowCnt_ff <= '0;
		end else if (lowCnt_ff != CNT_W'(MIN_CYC)) begin
			lowCnt_ff <= lowCnt_ff + 1'b1;
		end
	end

	assign reqQualified = (lowCnt_ff == CNT_W'(MIN_CYC));
	// Edge mode fires once per low period; level mode keeps firing while low
	assign setEvent = reqQualified && (levelMode || armed_ff);

	// Rearm only after the line is seen high again
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed_ff <= 1'b0;
		end else if (syncRst || reqN) begin
			armed_ff <= !syncRst;
		end else if (setEvent) begin
			armed_ff <= 1'b0;
		end
	end

	// Set beats clear so a request landing on the service cycle survives
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqLatch_ff <= 1'b0;
		end else if (syncRst) begin
			irqLatch_ff <= 1'b0;
		end else if (setEvent) begin
			irqLatch_ff <= 1'b1;
		end else if (clearReq) begin
			irqLatch_ff <= 1'b0;
		end
	end

	assign irqLatch = irqLatch_ff;

endmodule

// ==== sim/pin_source_model.sv ====
/*
 * Board-side sources of the request pin, both reset pins and the port B keys.
 * Assumes the bench raises the command inputs after a rising clock edge.
 */
`timescale 1ns/1ps
module pin_source_model (
	input wire logic clk,
	input wire logic irqLowCmd,
	input wire logic rstCmd,
	input wire logic lpCmd,
	input wire logic [7:0] keyCmd,
	input wire logic [7:0] portBOe,
	input wire logic [7:0] portBOut,
	input wire logic [7:0] portBPullupEn,
	output logic irqPinN,
	output logic resetPinN,
	output logic lowPowerResetInN,
	output logic [7:0] portBIn
);
	logic floatPat;

	// ****************************************
	// Pin levels
	// ****************************************
	initial floatPat = 1'b0;
	// Undriven line without pull-up must not look stable
	always @(posedge clk) begin
		floatPat <= ~floatPat;
	end
	assign irqPinN = ~irqLowCmd;
	assign resetPinN = ~rstCmd;
	assign lowPowerResetInN = ~lpCmd;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (portBOe[i]) begin
				portBIn[i] = portBOut[i];
			end else if (keyCmd[i]) begin
				portBIn[i] = 1'b0;
			end else begin
				portBIn[i] = portBPullupEn[i] ? 1'b1 : floatPat;
			end
		end
	end
endmodule

// ==== sim/irq_option_and_pin_reset_control_test.sv ====
/*
 * Self-checking bench for the option, request and reset control block.
 * Assumes the pin model beside the design; a second instance flips the watchdog, stop and sense options and clears the upper four port B options.
 */
`timescale 1ns/1ps
module irq_option_and_pin_reset_control_test;
	import irq_opt_pkg::*;
	logic clk, nrst, instrBoundary, iMaskFlag, stopExec, waitExec;
	logic irqLowCmd, rstCmd, lpCmd, psel, penable, pwrite, pready, pslverr;
	logic irqPinN, resetPinN, lowPowerResetInN, intStart, coreReset;
	logic busClkEn, cpuClkEn, watchdogRun, oscillatorOutputEn;
	logic [7:0] keyCmd, portAIn, portCIn, paddr, portAOut, portAOe, portBIn, portBOut, portBOe;
	logic [7:0] portBPullupEn, portCOut, portCOe;
	logic [31:0] pwdata, prdata, rd;
	logic err;
	logic altIntStart, altWatchdogRun;
	logic [7:0] altPullupEn;
	logic [31:0] altPrdata;
	int failures = 0, samples_checked = 0, cycles = 0, intCount = 0, altIntCount = 0;

	// ****************************************
	// Clock, instances, watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	irq_option_and_pin_reset_control irq_option_and_pin_reset_control_i (.clk(clk),
		.nrst(nrst), .resetPinN(resetPinN), .lowPowerResetInN(lowPowerResetInN),
		.irqPinN(irqPinN), .instrBoundary(instrBoundary), .iMaskFlag(iMaskFlag),
		.stopExec(stopExec), .waitExec(waitExec), .intStart(intStart), .coreReset(coreReset),
		.busClkEn(busClkEn), .cpuClkEn(cpuClkEn), .watchdogRun(watchdogRun),
		.oscillatorOutputEn(oscillatorOutputEn), .portAIn(portAIn), .portAOut(portAOut),
		.portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
		.portBPullupEn(portBPullupEn), .portCIn(portCIn), .portCOut(portCOut),
		.portCOe(portCOe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	pin_source_model pin_source_model_i (.clk(clk), .irqLowCmd(irqLowCmd), .rstCmd(rstCmd),
		.lpCmd(lpCmd), .keyCmd(keyCmd), .portBOe(portBOe), .portBOut(portBOut),
		.portBPullupEn(portBPullupEn), .irqPinN(irqPinN), .resetPinN(resetPinN),
		.lowPowerResetInN(lowPowerResetInN), .portBIn(portBIn));
	// Opposite options: no watchdog, stop as wait, level sense, upper keys off
	irq_option_and_pin_reset_control #(.WATCHDOG_OPTION_ENABLE(1'b0),
		.STOP_INSTRUCTION_OPTION_ENABLE(1'b0), .IRQ_LEVEL_OPTION(1'b1),
		.PORT_B_PULLUP_OPTION(8'h0f)) irq_option_and_pin_reset_control_alt_i (.clk(clk),
		.nrst(nrst), .resetPinN(resetPinN), .lowPowerResetInN(lowPowerResetInN),
		.irqPinN(irqPinN), .instrBoundary(instrBoundary), .iMaskFlag(iMaskFlag),
		.stopExec(stopExec), .waitExec(waitExec), .intStart(altIntStart), .coreReset(),
		.busClkEn(), .cpuClkEn(), .watchdogRun(altWatchdogRun), .oscillatorOutputEn(),
		.portAIn(portAIn), .portAOut(), .portAOe(), .portBIn(portBIn), .portBOut(),
		.portBOe(), .portBPullupEn(altPullupEn), .portCIn(portCIn), .portCOut(),
		.portCOe(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(altPrdata), .pready(), .pslverr());
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (intStart === 1'b1) intCount <= intCount + 1;
		if (altIntStart === 1'b1) altIntCount <= altIntCount + 1;
		if (cycles == 6000) begin
			failures = failures + 1;
			give_verdict();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic boundary(input logic masked);
		@(posedge clk);
		iMaskFlag <= masked;
		instrBoundary <= 1'b1;
		@(posedge clk);
		instrBoundary <= 1'b0;
		cyc(2);
	endtask
	task automatic busCount(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			if (busClkEn === 1'b1) c++;
		end
	endtask
	task automatic irqPulse(input int n);
		@(posedge clk);
		irqLowCmd <= 1'b1;
		cyc(n);
		irqLowCmd <= 1'b0;
		cyc(3);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic testStartup();
		int c;
		checkWord("porta dir", 32'h0, portAOe);
		checkWord("portb dir", 32'h0, portBOe);
		checkWord("portc dir", 32'h0, portCOe);
		checkWord("pullups", 32'h0000_00ff, portBPullupEn);
		checkWord("watchdog", 32'h1, watchdogRun);
		apb(1'b0, OPTION_OFS, 32'h0);
		checkWord("options", 32'h0000_ff03, rd);
		checkWord("alt options", 32'h0000_0f04, altPrdata);
		checkWord("alt watchdog", 32'h0, altWatchdogRun);
		checkWord("alt pullups", 32'h0000_000f, altPullupEn);
		apb(1'b0, 8'h40, 32'h0);
		checkWord("unmapped err", 32'h1, err);
		busCount(20, c);
		checkWord("bus clocks", 32'd10, c);
		$display("startup test done");
	endtask
	task automatic testRequest();
		int n0;
		int a0;
		irqPulse(3);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("short pulse latch", 32'h0, rd[0]);
		irqPulse(MIN_IRQ_PULSE_CYC + 1);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("latch set", 32'h1, rd[0]);
		n0 = intCount;
		a0 = altIntCount;
		boundary(1'b1);
		checkWord("masked start", n0, intCount);
		boundary(1'b0);
		checkWord("start", n0 + 1, intCount);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("latch cleared", 32'h0, rd[0]);
		irqLowCmd <= 1'b1;
		cyc(8);
		boundary(1'b0);
		boundary(1'b0);
		checkWord("edge once", n0 + 2, intCount);
		checkWord("level refire", a0 + 3, altIntCount);
		irqLowCmd <= 1'b0;
		// Line must be seen high before a key press can rearm edge sensing
		cyc(2);
		keyCmd <= 8'h04;
		cyc(8);
		keyCmd <= 8'h00;
		boundary(1'b0);
		boundary(1'b0);
		checkWord("keyscan once", n0 + 3, intCount);
		$display("request test done");
	endtask
	task automatic testPower();
		int c;
		@(posedge clk);
		stopExec <= 1'b1;
		@(posedge clk);
		stopExec <= 1'b0;
		cyc(2);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("stop mode", 32'h1, rd[3]);
		checkWord("alt stop as wait", 32'h1, altPrdata[3:2]);
		busCount(10, c);
		checkWord("stop bus clocks", 32'h0, c);
		irqPulse(MIN_IRQ_PULSE_CYC + 1);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("woken", 32'h0, rd[3]);
		boundary(1'b0);
		@(posedge clk);
		waitExec <= 1'b1;
		@(posedge clk);
		waitExec <= 1'b0;
		cyc(2);
		apb(1'b0, STATUS_OFS, 32'h0);
		checkWord("wait mode", 32'h1, rd[2]);
		irqPulse(MIN_IRQ_PULSE_CYC + 1);
		boundary(1'b0);
		$display("power test done");
	endtask
	task automatic testResets();
		int c;
		apb(1'b1, PORTA_DIR_OFS, 32'hff);
		apb(1'b1, PORTC_DIR_OFS, 32'hf0);
		cyc(1);
		checkWord("porta out", 32'hff, portAOe);
		checkWord("portc upper out", 32'hf0, portCOe);
		apb(1'b1, PORTA_DATA_OFS, 32'h3c);
		apb(1'b0, PORTA_DATA_OFS, 32'h0);
		checkWord("porta latch read", 32'h3c, rd);
		checkWord("porta data", 32'h3c, portAOut);
		apb(1'b0, PORTC_DATA_OFS, 32'h0);
		checkWord("portc pin read", 32'h05, rd);
		apb(1'b1, STATUS_OFS, 32'h0);
		checkWord("status write err", 32'h1, err);
		rstCmd <= 1'b1;
		cyc(3);
		checkWord("pin reset core", 32'h1, coreReset);
		checkWord("pin reset porta", 32'h0, portAOe);
		checkWord("pin reset portc", 32'h0, portCOe);
		checkWord("pin reset data", 32'h0, portAOut);
		rstCmd <= 1'b0;
		cyc(3);
		checkWord("core released", 32'h0, coreReset);
		apb(1'b1, PORTB_DIR_OFS, 32'h0f);
		apb(1'b0, PORTB_DATA_OFS, 32'h0);
		checkWord("portb read", 32'hf0, rd);
		lpCmd <= 1'b1;
		cyc(3);
		checkWord("osc halted", 32'h0, oscillatorOutputEn);
		checkWord("lp portb", 32'h0, portBOe);
		busCount(8, c);
		checkWord("lp bus clocks", 32'h0, c);
		checkWord("lp cpu clock", 32'h0, cpuClkEn);
		lpCmd <= 1'b0;
		cyc(4);
		$display("reset test done");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		{instrBoundary, iMaskFlag, stopExec, waitExec} = 4'h0;
		{irqLowCmd, rstCmd, lpCmd, psel, penable, pwrite} = 6'h00;
		keyCmd = 8'h00;
		portAIn = 8'h5a;
		portCIn = 8'ha5;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		cyc(8);
		testStartup();
		testRequest();
		testPower();
		testResets();
		give_verdict();
	end
endmodule
